// >>> hw/cpu_ops_regs.svh
`ifndef CPU_OPS_REGS_SVH
`define CPU_OPS_REGS_SVH

// Instruction word field positions
`define OPS_IC_HI       15
`define OPS_IC_LO       10
`define OPS_PFX_LO      12
`define OPS_ROW2_HI     9
`define OPS_ROW2_LO     8
`define OPS_ROW4_HI     11
`define OPS_ROW4_LO     8
`define OPS_COL_HI      7
`define OPS_COL_LO      4
`define OPS_LOW_HI      3
`define OPS_LOW_LO      0
`define OPS_IMM6_HI     9
`define OPS_IMM6_LO     4

// Six-bit instruction codes
`define OP_SKIP_LT_IMM  6'h30
`define OP_SKIP_GE_IMM  6'h31
`define OP_SKIP_EQ_IMM  6'h32
`define OP_SKIP_NE_IMM  6'h33
`define OP_SKIP_EQ_REG  6'h12
`define OP_SKIP_NE_REG  6'h13
`define OP_CARRY_LT     6'h1c
`define OP_CARRY_LT_C   6'h1d
`define OP_MOVE_IMM     6'h07
`define OP_MOVE_ROW     6'h0f
`define OP_IND_DEST     6'h1e
`define OP_IND_SRC      6'h1f
`define OP_SYSTEM       6'h3f
`define OP_IN_ONE       6'h38
`define OP_IN_TWO       6'h39
`define OP_IN_THREE     6'h3a
`define OP_OUT_ONE      6'h3b
`define OP_OUT_TWO      6'h3c
`define OP_OUT_THREE    6'h3d
`define OP_OR_REG       6'h0c
`define OP_AND_REG      6'h0d
`define OP_XOR_REG      6'h0e
`define OP_OR_IMM       6'h04
`define OP_AND_IMM      6'h05
`define OP_XOR_IMM      6'h06

// Four-bit prefixes of the wide-row load and store
`define PFX_LOAD        4'h5
`define PFX_STORE       4'h6

// Low-field sub-codes under the system code
`define SUB_LOAD_PAGE   4'h2
`define SUB_COPY_TABLE  4'h9

// Reset values
`define RST_CARRY       1'h0
`define RST_PAGE        5'h00
`define RST_TABLE       14'h0000

`endif

// >>> hw/cpu_ops_pkg.sv
package cpu_ops_pkg;

  // One instruction offered to the block
  typedef struct packed {
    logic        valid;  // Word present this cycle
    logic [15:0] word;   // Instruction word
  } instr_t;

  // Port groups addressed by the port instructions
  typedef enum logic [1:0] {
    GROUP_ONE,
    GROUP_TWO,
    GROUP_THREE,
    GROUP_NONE
  } port_group_t;

  // Input port selection, answered in the same cycle
  typedef struct packed {
    logic        valid;
    port_group_t group;
    logic [3:0]  port_code;
  } in_sel_t;

  // Output port write
  typedef struct packed {
    logic        strobe;
    port_group_t group;
    logic [3:0]  port_code;
    logic [3:0]  data;
  } out_wr_t;

endpackage

// >>> hw/cpu_compare_move_logic_ops.sv
`timescale 1ns/100ps
`include "cpu_ops_regs.svh"
module cpu_compare_move_logic_ops #(
  parameter int MEM_WORDS = 512  // Data memory nibbles
) (
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire cpu_ops_pkg::instr_t      instr,
  input  wire logic [15:0]              data_reg,
  output      cpu_ops_pkg::in_sel_t     in_sel,
  input  wire logic [3:0]               in_data,
  output      cpu_ops_pkg::out_wr_t     out_wr,
  output      logic                     skip_pending,
  output      logic                     carry_flag,
  output      logic [4:0]               page_reg,
  output      logic [13:0]              table_addr_reg
);

  // Address reach must match page plus register content
  generate
    if (MEM_WORDS != 512) begin : g_bad_size
      $error("MEM_WORDS must be 512");
    end
  endgenerate

  logic [3:0]  mem_q [MEM_WORDS];  // Data memory, general registers at 0..15
  logic        skip_q;             // Next instruction is to be suppressed
  logic        carry_q;            // Carry flag
  logic [4:0]  page_q;             // Page register for indirect moves
  logic [13:0] table_q;            // Table address register
  cpu_ops_pkg::out_wr_t out_q;     // Registered output port write

  // Instruction fields
  logic [5:0]  ic;
  logic [3:0]  pfx;
  logic [3:0]  col;
  logic [3:0]  low;
  logic [1:0]  row_field;
  logic [3:0]  wide_row;
  logic [5:0]  imm6;
  logic        exec;               // Instruction really executes
  logic        is_load;
  logic        is_store;

  assign ic        = instr.word[`OPS_IC_HI:`OPS_IC_LO];
  assign pfx       = instr.word[`OPS_IC_HI:`OPS_PFX_LO];
  assign col       = instr.word[`OPS_COL_HI:`OPS_COL_LO];
  assign low       = instr.word[`OPS_LOW_HI:`OPS_LOW_LO];
  assign row_field = instr.word[`OPS_ROW2_HI:`OPS_ROW2_LO];
  assign wide_row  = instr.word[`OPS_ROW4_HI:`OPS_ROW4_LO];
  assign imm6      = instr.word[`OPS_IMM6_HI:`OPS_IMM6_LO];
  assign is_load   = (pfx == `PFX_LOAD);
  assign is_store  = (pfx == `PFX_STORE);
  // A suppressed instruction does nothing but clear the skip flag
  assign exec      = instr.valid && !skip_q;

  // Memory addresses; only load and store see the wide row
  logic [8:0] mem_addr;
  logic [8:0] reg_addr;
  logic [8:0] row_src_addr;
  logic [8:0] ind_addr;
  assign mem_addr     = (is_load || is_store) ? {1'b0, wide_row, col}
                                              : {3'h0, row_field, col};
  assign reg_addr     = {5'h00, low};
  assign row_src_addr = {3'h0, row_field, low};

  // Operand reads
  logic [3:0] mem_val;
  logic [3:0] reg_val;
  logic [3:0] ind_val;
  assign mem_val  = mem_q[mem_addr];
  assign reg_val  = mem_q[reg_addr];
  // Indirect address is page register over register content
  assign ind_addr = {page_q, reg_val};
  assign ind_val  = mem_q[ind_addr];

  // Compare results
  logic       lt_imm;
  logic [4:0] mem_plus_c;
  assign lt_imm     = mem_val < low;
  assign mem_plus_c = {1'b0, mem_val} + {4'h0, carry_q};

  // Skip condition of this instruction
  logic skip_cond;
  always_comb begin
    case (ic)
      `OP_SKIP_LT_IMM: skip_cond = lt_imm;
      `OP_SKIP_GE_IMM: skip_cond = !lt_imm;
      `OP_SKIP_EQ_IMM: skip_cond = (mem_val == low);
      `OP_SKIP_NE_IMM: skip_cond = (mem_val != low);
      `OP_SKIP_EQ_REG: skip_cond = (reg_val == mem_val);
      `OP_SKIP_NE_REG: skip_cond = (reg_val != mem_val);
      // Every other instruction never skips
      default:         skip_cond = 1'b0;
    endcase
  end

  // Input port selection goes out combinationally, data returns same cycle
  always_comb begin
    in_sel.valid     = 1'b0;
    in_sel.group     = cpu_ops_pkg::GROUP_NONE;
    in_sel.port_code = low;
    if (exec) begin
      case (ic)
        `OP_IN_ONE: begin
          in_sel.valid = 1'b1;
          in_sel.group = cpu_ops_pkg::GROUP_ONE;
        end
        `OP_IN_TWO: begin
          in_sel.valid = 1'b1;
          in_sel.group = cpu_ops_pkg::GROUP_TWO;
        end
        `OP_IN_THREE: begin
          in_sel.valid = 1'b1;
          in_sel.group = cpu_ops_pkg::GROUP_THREE;
        end
        default: begin
          in_sel.valid = 1'b0;
        end
      endcase
    end
  end

  // Single memory write port; one write per instruction at most
  logic       wr_en;
  logic [8:0] wr_addr;
  logic [3:0] wr_data;
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = mem_addr;
    wr_data = mem_val;
    if (exec) begin
      if (is_load) begin
        wr_en   = 1'b1;
        wr_addr = reg_addr;
        wr_data = mem_val;
      end else if (is_store) begin
        wr_en   = 1'b1;
        wr_data = reg_val;
      end else begin
        case (ic)
          `OP_MOVE_IMM: begin
            wr_en   = 1'b1;
            wr_data = low;
          end
          // Column in the low field is the source, middle one the target
          `OP_MOVE_ROW: begin
            wr_en   = 1'b1;
            wr_data = mem_q[row_src_addr];
          end
          `OP_IND_DEST: begin
            wr_en   = 1'b1;
            wr_addr = ind_addr;
            wr_data = mem_val;
          end
          `OP_IND_SRC: begin
            wr_en   = 1'b1;
            wr_data = ind_val;
          end
          `OP_IN_ONE, `OP_IN_TWO, `OP_IN_THREE: begin
            wr_en   = 1'b1;
            wr_data = in_data;
          end
          `OP_OR_REG: begin
            wr_en   = 1'b1;
            wr_addr = reg_addr;
            wr_data = reg_val | mem_val;
          end
          `OP_AND_REG: begin
            wr_en   = 1'b1;
            wr_addr = reg_addr;
            wr_data = reg_val & mem_val;
          end
          `OP_XOR_REG: begin
            wr_en   = 1'b1;
            wr_addr = reg_addr;
            wr_data = reg_val ^ mem_val;
          end
          `OP_OR_IMM: begin
            wr_en   = 1'b1;
            wr_data = mem_val | low;
          end
          `OP_AND_IMM: begin
            wr_en   = 1'b1;
            wr_data = mem_val & low;
          end
          `OP_XOR_IMM: begin
            wr_en   = 1'b1;
            wr_data = mem_val ^ low;
          end
          // Compares and all others leave memory alone
          default: begin
            wr_en   = 1'b0;
          end
        endcase
      end
    end
  end

  // Memory write; no reset, contents are undefined at power-up
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Skip flag: set by a true condition, consumed by the next word
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      skip_q <= 1'b0;
    end else if (instr.valid) begin
      skip_q <= exec && skip_cond;
    end
  end

  // Carry changes only under the two carry compares
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      carry_q <= `RST_CARRY;
    end else if (exec && ic == `OP_CARRY_LT) begin
      carry_q <= (reg_val < mem_val);
    end else if (exec && ic == `OP_CARRY_LT_C) begin
      carry_q <= ({1'b0, reg_val} < mem_plus_c);
    end
  end

  // Page and table registers under the system code
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      page_q  <= `RST_PAGE;
      table_q <= `RST_TABLE;
    end else if (exec && !is_load && !is_store && ic == `OP_SYSTEM) begin
      // Page holds five bits, so the top immediate bit is dropped
      if (low == `SUB_LOAD_PAGE) begin
        page_q <= imm6[4:0];
      end else if (low == `SUB_COPY_TABLE) begin
        table_q <= data_reg[13:0];
      end
    end
  end

  // Output port write, registered so the port sees stable data
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_q <= '0;
    end else begin
      out_q.strobe    <= 1'b0;
      out_q.port_code <= low;
      out_q.data      <= mem_val;
      if (exec) begin
        case (ic)
          `OP_OUT_ONE: begin
            out_q.strobe <= 1'b1;
            out_q.group  <= cpu_ops_pkg::GROUP_ONE;
          end
          `OP_OUT_TWO: begin
            out_q.strobe <= 1'b1;
            out_q.group  <= cpu_ops_pkg::GROUP_TWO;
          end
          `OP_OUT_THREE: begin
            out_q.strobe <= 1'b1;
            out_q.group  <= cpu_ops_pkg::GROUP_THREE;
          end
          default: begin
            out_q.strobe <= 1'b0;
          end
        endcase
      end
    end
  end

  assign out_wr         = out_q;
  assign skip_pending   = skip_q;
  assign carry_flag     = carry_q;
  assign page_reg       = page_q;
  assign table_addr_reg = table_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_skip_lt_imm: assert property (
    (exec && ic == `OP_SKIP_LT_IMM) |=> skip_q == ($past(mem_val) < $past(low)))
    else $error("lt-immediate skip wrong");
  chk_skip_eq_reg: assert property (
    (exec && ic == `OP_SKIP_EQ_REG) |=> skip_q == ($past(reg_val) == $past(mem_val)))
    else $error("register-equal skip wrong");
  chk_skip_ne_reg: assert property (
    (exec && ic == `OP_SKIP_NE_REG) |=> skip_q == ($past(reg_val) != $past(mem_val)))
    else $error("register-differ skip wrong");
  chk_carry_lt: assert property (
    (exec && ic == `OP_CARRY_LT) |=> carry_q == ($past(reg_val) < $past(mem_val)))
    else $error("carry compare wrong");
  chk_load_reg: assert property (
    (exec && is_load) |-> wr_en && wr_addr == reg_addr && wr_data == mem_val)
    else $error("load write wrong");
  chk_store_wide: assert property (
    (exec && is_store) |-> wr_addr == {1'b0, wide_row, col} && wr_data == reg_val)
    else $error("store address wrong");
  chk_out_strobe: assert property (
    (exec && ic == `OP_OUT_ONE) |=> out_wr.strobe && out_wr.group == cpu_ops_pkg::GROUP_ONE
      && out_wr.data == $past(mem_val))
    else $error("output group one wrong");
  chk_or_reg: assert property (
    (exec && ic == `OP_OR_REG) |-> wr_addr == reg_addr && wr_data == (reg_val | mem_val))
    else $error("register or wrong");
  chk_suppress: assert property (
    (instr.valid && skip_q) |-> !wr_en && !in_sel.valid ##1 !skip_q && $stable(carry_q))
    else $error("skipped instruction acted");
  chk_cmp_keeps: assert property (
    (exec && !is_load && !is_store && ic[5:2] == 4'hc) |-> !wr_en ##1 $stable(carry_q))
    else $error("compare changed state");
  chk_carry_lt_c: assert property (
    (exec && ic == `OP_CARRY_LT_C) |=> carry_q ==
      ({1'b0, $past(reg_val)} < ({1'b0, $past(mem_val)} + {4'h0, $past(carry_q)})))
    else $error("carry compare with carry wrong");
  chk_move_imm: assert property (
    (exec && ic == `OP_MOVE_IMM) |-> wr_en && wr_addr == mem_addr && wr_data == low)
    else $error("immediate move wrong");
  chk_ind_dest: assert property (
    (exec && ic == `OP_IND_DEST) |-> wr_en && wr_addr == {page_q, reg_val} && wr_data == mem_val)
    else $error("indirect destination move wrong");
  chk_xor_imm: assert property (
    (exec && ic == `OP_XOR_IMM) |-> wr_en && wr_addr == mem_addr && wr_data == (mem_val ^ low))
    else $error("memory xor immediate wrong");

  cov_skip_taken: cover property (exec && skip_cond ##1 instr.valid && skip_q);
  cov_carry_set:  cover property (exec && ic == `OP_CARRY_LT_C ##1 carry_q);
  cov_indirect:   cover property (exec && ic == `OP_IND_DEST);
  cov_in_two:     cover property (in_sel.valid && in_sel.group == cpu_ops_pkg::GROUP_TWO);
  cov_out_three:  cover property (out_wr.strobe && out_wr.group == cpu_ops_pkg::GROUP_THREE);

endmodule

// >>> test/testbench.sv
`timescale 1ns/100ps
// Compare helper: counts every check, reports and counts each miss
`define CHK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
    end \
  end
module testbench;
  logic                 mclk;            // 20 MHz system clock
  logic                 reset_n;         // Async reset, active low
  cpu_ops_pkg::instr_t  instr;           // Instruction offered each cycle
  logic [15:0]          data_reg;        // Data register feed
  cpu_ops_pkg::in_sel_t in_sel;          // Input port selection
  logic [3:0]           in_data;         // Input port nibble
  cpu_ops_pkg::out_wr_t out_wr;          // Output port write
  logic                 skip_pending;    // Next word suppressed
  logic                 carry_flag;      // Carry flag
  logic [4:0]           page_reg;        // Page register
  logic [13:0]          table_addr_reg;  // Table address register
  int                   fails;           // Mismatch count
  int                   cmp_count;       // Comparison count
  int                   seed;            // Random seed
  int                   mem[512];        // Model data memory
  int                   m_carry;         // Model carry
  int                   m_page;          // Model page register
  int                   m_table;         // Model table address
  int                   m_skip;          // Model skip flag
  int                   m_strobe;        // Expected output pulse
  int                   m_group;         // Expected output group
  int                   m_code;          // Expected output port code
  int                   m_data;          // Expected output nibble
  // Decoded codes plus one undecoded (add) to prove it never skips
  logic [5:0]           codes[28] = '{6'h30, 6'h31, 6'h32, 6'h33, 6'h12, 6'h13, 6'h1c, 6'h1d, 6'h14, 6'h18,
                                      6'h07, 6'h0f, 6'h1e, 6'h1f, 6'h3f, 6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3c,
                                      6'h3d, 6'h0c, 6'h0d, 6'h0e, 6'h04, 6'h05, 6'h06, 6'h00};

  cpu_compare_move_logic_ops #(
    .MEM_WORDS (512)
  ) uut (
    .mclk           (mclk),
    .reset_n        (reset_n),
    .instr          (instr),
    .data_reg       (data_reg),
    .in_sel         (in_sel),
    .in_data        (in_data),
    .out_wr         (out_wr),
    .skip_pending   (skip_pending),
    .carry_flag     (carry_flag),
    .page_reg       (page_reg),
    .table_addr_reg (table_addr_reg)
  );

  // Free-running clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Registered outputs against model state after the previous edge
  task automatic check_regs();
    `CHK("skip_pending", m_skip, skip_pending)
    `CHK("carry_flag", m_carry, carry_flag)
    `CHK("page_reg", m_page, page_reg)
    `CHK("table_addr_reg", m_table, table_addr_reg)
    `CHK("out_wr.strobe", m_strobe, out_wr.strobe)
    // Group, code and data only mean something under a pulse
    if (m_strobe == 1) begin
      `CHK("out_wr.group", m_group, out_wr.group)
      `CHK("out_wr.port_code", m_code, out_wr.port_code)
      `CHK("out_wr.data", m_data, out_wr.data)
    end
  endtask

  // Reference behaviour of one offered word
  task automatic execute(input logic [15:0] w);
    int ic;
    int lo;
    int a;
    int mv;
    int rv;
    int ind;
    ic = w[15:10];
    lo = w[3:0];
    a = w[9:4];
    mv = mem[a];
    rv = mem[lo];
    ind = {m_page[4:0], rv[3:0]};
    m_strobe = 0;
    // Suppressed word only clears the flag
    if (m_skip == 1) begin
      m_skip = 0;
      `CHK("in_sel.valid", 0, in_sel.valid)
      return;
    end
    if (ic >= 'h38 && ic <= 'h3a) begin
      `CHK("in_sel.valid", 1, in_sel.valid)
      `CHK("in_sel.group", ic - 'h38, in_sel.group)
      `CHK("in_sel.port_code", lo, in_sel.port_code)
      mem[a] = in_data;
    end else `CHK("in_sel.valid", 0, in_sel.valid)
    case (ic)
      'h30: m_skip = (mv < lo);
      'h31: m_skip = (mv >= lo);
      'h32: m_skip = (mv == lo);
      'h33: m_skip = (mv != lo);
      'h12: m_skip = (rv == mv);
      'h13: m_skip = (rv != mv);
      'h1c: m_carry = (rv < mv);
      'h1d: m_carry = (rv < mv + m_carry);
      'h07: mem[a] = lo;
      'h0f: mem[a] = mem[{w[9:8], w[3:0]}];
      'h1e: mem[ind] = mv;
      'h1f: mem[a] = mem[ind];
      'h3f: begin
        if (lo == 2) m_page = w[8:4];
        else if (lo == 9) m_table = data_reg[13:0];
      end
      'h3b, 'h3c, 'h3d: begin
        m_strobe = 1;
        m_group = ic - 'h3b;
        m_code = lo;
        m_data = mv;
      end
      'h0c: mem[lo] = rv | mv;
      'h0d: mem[lo] = rv & mv;
      'h0e: mem[lo] = rv ^ mv;
      'h04: mem[a] = mv | lo;
      'h05: mem[a] = mv & lo;
      'h06: mem[a] = mv ^ lo;
      default: ;
    endcase
    // Wide row only under the four-bit prefixes
    if (w[15:12] == 4'h5) mem[lo] = mem[w[11:4]];
    if (w[15:12] == 4'h6) mem[w[11:4]] = rv;
  endtask

  // One cycle of traffic, checked at the falling edge once settled
  task automatic issue(input logic [15:0] w, input bit v);
    @(posedge mclk);
    instr.valid <= v;
    instr.word <= w;
    in_data <= 4'($random(seed));
    data_reg <= 16'($random(seed));
    @(negedge mclk);
    check_regs();
    if (v) begin
      execute(w);
    end else begin
      // Idle cycles keep the skip flag
      m_strobe = 0;
      `CHK("in_sel.valid", 0, in_sel.valid)
    end
  endtask

  // Random legal word with the fields the code needs
  function automatic logic [15:0] rand_word();
    logic [15:0] w;
    logic [5:0]  c;
    w = 16'($random(seed));
    c = codes[{$random(seed)} % 28];
    w[15:10] = c;
    if (c == 6'h14 || c == 6'h18) w[11:10] = 2'($random(seed));
    if (c == 6'h3f) w[3:0] = w[9] ? 4'h2 : 4'h9;
    return w;
  endfunction

  // Clears model state the way reset clears the design
  task automatic model_reset();
    m_carry = 0;
    m_page = 0;
    m_table = 0;
    m_skip = 0;
    m_strobe = 0;
  endtask

  // Main sequence
  initial begin
    fails = 0;
    cmp_count = 0;
    seed = 32'h16f0ca86;
    reset_n = 1'b0;
    instr = '0;
    data_reg = 16'h0000;
    in_data = 4'h0;
    model_reset();
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    check_regs();
    // Fill low memory through all three input groups
    for (int i = 0; i < 64; i++) issue({6'h38 + 6'(i % 3), i[5:0], 4'(i)}, 1'b1);
    // Fill the wide rows by stores
    for (int i = 64; i < 256; i++) issue({4'h6, i[7:0], 4'($random(seed))}, 1'b1);
    // Fill upper pages by indirect moves
    for (int p = 16; p < 32; p++) begin
      issue({6'h3f, 1'b0, p[4:0], 4'h2}, 1'b1);
      for (int v = 0; v < 16; v++) begin
        issue({6'h07, 6'h00, v[3:0]}, 1'b1);
        issue({6'h1e, 6'(16 + v), 4'h0}, 1'b1);
      end
    end
    // Random traffic, back to back with some idle cycles
    for (int n = 0; n < 3000; n++) issue(rand_word(), ({$random(seed)} % 8) != 0);
    // Reset in mid-run; memory is kept
    @(posedge mclk);
    reset_n <= 1'b0;
    instr.valid <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    model_reset();
    @(negedge mclk);
    check_regs();
    for (int n = 0; n < 500; n++) issue(rand_word(), 1'b1);
    end_of_test();
  end
endmodule
